// *** rtl/ppfs_consts.vh ***
// Purpose: constants for the port pin function select block
// Assumes: APB byte addressing, 32-bit data
// Notes: offsets are byte addresses
`ifndef PPFS_CONSTS_VH
`define PPFS_CONSTS_VH
// Register byte offsets
`define PPFS_OFF_P5DIR 12'h000
`define PPFS_OFF_P5OUT 12'h004
`define PPFS_OFF_P6DIR 12'h008
`define PPFS_OFF_PERIPH 12'h00c
`define PPFS_OFF_INTEN 12'h010
`define PPFS_OFF_INTSEL 12'h014
`define PPFS_OFF_MODE 12'h018
`define PPFS_OFF_P5IN 12'h01c
`define PPFS_OFF_ISTAT 12'h020
`define PPFS_OFF_IMASK 12'h024
// Reset values
`define PPFS_RST_BYTE 8'h00
`define PPFS_RST_SEL 8'hff
// Peripheral control field positions
`define PPFS_PC_PWM_B 7
`define PPFS_PC_PWM_A 6
`define PPFS_PC_S2_RX 5
`define PPFS_PC_S2_TX 4
`define PPFS_PC_S1_RX 3
`define PPFS_PC_S1_TX 2
`define PPFS_PC_S0_RX 1
`define PPFS_PC_S0_TX 0
// Mode field: bit0 extended, bit1 wide bus
`define PPFS_MODE_EXT 0
`define PPFS_MODE_WIDE 1
`endif

// *** rtl/ppfs_top.v ***
// Purpose: pin function select for port 5 and port 6 direction
// Assumes: pins asynchronous to mclk_i; APB slave, zero wait states
// Notes: interrupt status bits are write-one-to-clear
// What this block does
// [RULE1] PWM B enable drives pin 7 as channel1
// [RULE2] PWM A enable drives pin 6 as channel0
// [RULE3] Serial 2 receive enable uses pin 5
// [RULE4] Serial 2 transmit enable drives pin 4
// [RULE5] Serial 1 receive enable uses pin 3
// [RULE6] Serial 1 transmit enable drives pin 2
// [RULE7] Serial 0 receive enable uses pin 1
// [RULE8] Serial 0 transmit enable drives pin 0
// [RULE9] Peripheral off: direction picks input or output
// [RULE10] Pins feed interrupts 15..8 when enabled/selected
// [RULE11] Software clears direction before using interrupts
// [RULE12] Wide extended mode: port 6 is bus
// [RULE13] Otherwise port 6 follows direction bits
// [RULE14] Port 6 serves as low data byte
// [RULE15] Port 5 read: output data or pin
// [RULE16] Pin levels reach interrupt logic synchronised
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ppfs_consts.vh"
module ppfs_top
(
   // Clock and reset
   input wire mclk_i,
   input wire rst_n_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // Port 5 pins
   input wire [7:0] p5_pin_i,
   output wire [7:0] p5_pin_o,
   output wire [7:0] p5_pin_oe_o,
   // Peripheral side of port 5
   input wire pwm_ch1_out_i,
   input wire pwm_ch0_out_i,
   input wire ser2_tx_out_i,
   input wire ser1_tx_out_i,
   input wire ser0_tx_out_i,
   output wire ser2_rx_in_o,
   output wire ser1_rx_in_o,
   output wire ser0_rx_in_o,
   output wire [7:0] ext_int_hi_o,
   // Port 6 pins and bus side
   input wire [7:0] p6_pin_i,
   output wire [7:0] p6_pin_oe_o,
   output wire p6_is_bus_o,
   // Interrupt
   output wire irq_o
);
   // Reset release synchroniser
   // Assert is immediate; release waits two edges so no
   // flop leaves reset on an edge close to the release
   reg rst_s1_reg;
   reg rst_s2_reg;
   wire rst_n;
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   // Everything below resets from this copy
   assign rst_n = rst_s2_reg;

   // Software registers
   // All of them reset from the synchronised copy
   // Direction registers are write only, as on the pins
   reg [7:0] port5_direction_reg; // Port 5 direction, write only
   reg [7:0] port5_out_value_reg; // Port 5 output data
   reg [7:0] port6_direction_reg; // Port 6 direction, write only
   reg [7:0] periph_ctrl_reg; // Peripheral enables, one per pin
   reg [7:0] ext_int_enable_hi_reg; // Interrupt enables 15..8
   reg [7:0] ext_int_select_hi_reg; // Interrupt input select 15..8
   reg [1:0] mode_reg; // Operating mode
   reg [7:0] istat_reg; // Sticky pin-edge status
   reg [7:0] imask_reg; // Interrupt mask
   // Pin synchronisers
   reg [7:0] p5_s1_reg;
   reg [7:0] p5_s2_reg;
   reg [7:0] p5_s3_reg;

   // Register access strobes
   // Writes land on the access edge; reads are captured
   // one edge earlier, in the setup cycle
   wire wr_en = psel_i & penable_i & pwrite_i;
   wire rd_en = psel_i & ~pwrite_i;

   // Byte offset hit test, used for every register write
   // Full 12-bit compare, so no register shows up twice
   // in the map under an alias
   function hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   // Register writes
   // Each register decodes its own offset, so one write
   // touches at most one of them
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port5_direction_reg <= `PPFS_RST_BYTE;
         port5_out_value_reg <= `PPFS_RST_BYTE;
         port6_direction_reg <= `PPFS_RST_BYTE;
         periph_ctrl_reg <= `PPFS_RST_BYTE;
         ext_int_enable_hi_reg <= `PPFS_RST_BYTE;
         // Select resets to ones so no pin is routed yet
         ext_int_select_hi_reg <= `PPFS_RST_SEL;
         // Single-chip mode after reset
         mode_reg <= 2'h0;
         imask_reg <= `PPFS_RST_BYTE;
      end
      else if (wr_en)
      begin
         if (hit(paddr_i, `PPFS_OFF_P5DIR))
            port5_direction_reg <= pwdata_i[7:0];
         if (hit(paddr_i, `PPFS_OFF_P5OUT))
            port5_out_value_reg <= pwdata_i[7:0];
         if (hit(paddr_i, `PPFS_OFF_P6DIR))
            port6_direction_reg <= pwdata_i[7:0];
         if (hit(paddr_i, `PPFS_OFF_PERIPH))
            periph_ctrl_reg <= pwdata_i[7:0];
         if (hit(paddr_i, `PPFS_OFF_INTEN))
            ext_int_enable_hi_reg <= pwdata_i[7:0];
         if (hit(paddr_i, `PPFS_OFF_INTSEL))
            ext_int_select_hi_reg <= pwdata_i[7:0];
         if (hit(paddr_i, `PPFS_OFF_MODE))
            mode_reg <= pwdata_i[1:0];
         if (hit(paddr_i, `PPFS_OFF_IMASK))
            imask_reg <= pwdata_i[7:0];
      end
   end

   // Pin level synchroniser; stage one feeds stage two only
   // Stage three only serves the falling-edge detector;
   // resetting to ones matches the idle level of the lines
   // so no false edge follows reset
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p5_s1_reg <= 8'hff;
         p5_s2_reg <= 8'hff;
         p5_s3_reg <= 8'hff;
      end
      else
      begin
         p5_s1_reg <= p5_pin_i;
         p5_s2_reg <= p5_s1_reg; // see [RULE16]
         p5_s3_reg <= p5_s2_reg;
      end
   end

   // Interrupt request lines are active low, so route the level
   // A pin is routed when enabled or when its select bit is
   // cleared; unrouted lines sit high, the inactive level
   wire [7:0] int_route = ext_int_enable_hi_reg | ~ext_int_select_hi_reg; // see [RULE10]
   assign ext_int_hi_o = p5_s2_reg | ~int_route; // see [RULE10] see [RULE16]

   // Falling edge on a routed line sets status; set beats clear
   // A clear that meets a new edge keeps the bit set, so an
   // edge is never lost to a late clear
   wire [7:0] fall_evt = p5_s3_reg & ~p5_s2_reg & int_route;
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         // Nothing pending after reset
         istat_reg <= `PPFS_RST_BYTE;
      else if (wr_en && hit(paddr_i, `PPFS_OFF_ISTAT))
         istat_reg <= (istat_reg & ~pwdata_i[7:0]) | fall_evt;
      else
         istat_reg <= istat_reg | fall_evt;
   end
   // Level output, high while any unmasked bit is set
   assign irq_o = |(istat_reg & imask_reg);

   // Peripheral overrides ignore the direction bits
   wire [7:0] periph_out;
   assign periph_out[7] = pwm_ch1_out_i; // see [RULE1]
   assign periph_out[6] = pwm_ch0_out_i; // see [RULE2]
   // Receive pins carry no output value; tie them low
   assign periph_out[5] = 1'b0;
   assign periph_out[4] = ser2_tx_out_i; // see [RULE4]
   assign periph_out[3] = 1'b0;
   assign periph_out[2] = ser1_tx_out_i; // see [RULE6]
   assign periph_out[1] = 1'b0;
   assign periph_out[0] = ser0_tx_out_i; // see [RULE8]
   // Pins whose peripheral function is an output
   // Bits 7, 6, 4, 2 and 0 drive; 5, 3 and 1 receive
   localparam [7:0] PERIPH_DRIVES = 8'hd5;

   // Output enable and value per pin
   // Every pin is handled alike, so one loop covers them;
   // defaults come first so no latch is inferred
   reg [7:0] oe_next;
   reg [7:0] out_next;
   integer i;
   always @*
   begin
      oe_next = 8'h00;
      out_next = 8'h00;
      for (i = 0; i < 8; i = i + 1)
      begin
         if (periph_ctrl_reg[i])
         begin
            // Peripheral owns pin; receive pins stay undriven
            oe_next[i] = PERIPH_DRIVES[i]; // see [RULE1] see [RULE2] see [RULE4] see [RULE6] see [RULE8]
            out_next[i] = periph_out[i];
         end
         else
         begin
            // General port: direction decides
            oe_next[i] = port5_direction_reg[i]; // see [RULE9]
            out_next[i] = port5_out_value_reg[i];
         end
      end
   end
   // Enable and value leave the block combinationally
   assign p5_pin_oe_o = oe_next;
   assign p5_pin_o = out_next;

   // Receive inputs, idle high when the function is off
   // Idle high keeps a disabled receiver from seeing a
   // false start bit
   assign ser2_rx_in_o = periph_ctrl_reg[`PPFS_PC_S2_RX] ? p5_s2_reg[5] : 1'b1; // see [RULE3]
   assign ser1_rx_in_o = periph_ctrl_reg[`PPFS_PC_S1_RX] ? p5_s2_reg[3] : 1'b1; // see [RULE5]
   assign ser0_rx_in_o = periph_ctrl_reg[`PPFS_PC_S0_RX] ? p5_s2_reg[1] : 1'b1; // see [RULE7]

   // Port 6: wide bus mode hands pins to the bus controller
   // Bus mode needs both the extended and the wide bit; the
   // bus controller then owns the drivers, so enables are zero
   // Port 6 input levels are not read here; their data path
   // lives outside this block
   wire p6_bus = mode_reg[`PPFS_MODE_EXT] & mode_reg[`PPFS_MODE_WIDE]; // see [RULE12] see [RULE14]
   assign p6_is_bus_o = p6_bus;
   assign p6_pin_oe_o = p6_bus ? 8'h00 : port6_direction_reg; // see [RULE13]

   // Port 5 read value mixes output latch and live pins
   // Live pins come from the synchroniser, two cycles late
   wire [7:0] p5_read = (port5_out_value_reg & port5_direction_reg) |
                        (p5_s2_reg & ~port5_direction_reg); // see [RULE15]

   // Read mux; direction registers are write only and read zero
   reg [7:0] rdata_next;
   reg known_next;
   always @*
   begin
      rdata_next = 8'h00;
      known_next = 1'b1;
      case (paddr_i)
         `PPFS_OFF_P5DIR: rdata_next = 8'h00;
         `PPFS_OFF_P5OUT: rdata_next = port5_out_value_reg;
         `PPFS_OFF_P6DIR: rdata_next = 8'h00;
         `PPFS_OFF_PERIPH: rdata_next = periph_ctrl_reg;
         `PPFS_OFF_INTEN: rdata_next = ext_int_enable_hi_reg;
         `PPFS_OFF_INTSEL: rdata_next = ext_int_select_hi_reg;
         `PPFS_OFF_MODE: rdata_next = {6'h00, mode_reg};
         `PPFS_OFF_P5IN: rdata_next = p5_read;
         `PPFS_OFF_ISTAT: rdata_next = istat_reg;
         `PPFS_OFF_IMASK: rdata_next = imask_reg;
         // Unknown offsets read zero and flag an error
         default: known_next = 1'b0;
      endcase
   end

   // Read data is registered in the setup cycle
   // Captured early so it stands through the whole access
   // phase without a wait state
   reg [7:0] prdata_reg;
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         prdata_reg <= 8'h00;
      else if (rd_en && !penable_i)
         prdata_reg <= rdata_next;
   end
   // Upper bits are unused and read zero
   assign prdata_o = {24'h000000, prdata_reg};
   // Every register answers at once
   assign pready_o = 1'b1;
   // Unmapped addresses answer with an error
   assign pslverr_o = psel_i & penable_i & ~known_next;
endmodule
`default_nettype wire

// *** verif/ppfs_top_asserts.sv ***
// Purpose: checks on pin routing of port 5 and port 6
// Assumes: helper copies follow APB writes at the access edge
// Notes: rx path has two sync flops
`timescale 1ns/1ps
`default_nettype none
`include "ppfs_consts.vh"
module ppfs_top_asserts
(
   // Clock, reset and APB
   input wire logic mclk_i, rst_n_i, psel_i, penable_i, pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   // Pins and peripheral side
   input wire logic [7:0] p5_pin_i, p5_pin_o, p5_pin_oe_o, p6_pin_oe_o,
   input wire logic pwm_ch1_out_i, pwm_ch0_out_i, ser2_tx_out_i, ser1_tx_out_i, ser0_tx_out_i,
   input wire logic ser2_rx_in_o, ser1_rx_in_o, ser0_rx_in_o, p6_is_bus_o, irq_o,
   input wire logic [7:0] ext_int_hi_o
);
   logic [7:0] pc, dir, out, p6d; // Shadow registers
   logic [7:0] en, sel; // Interrupt enable and select shadows
   // Shadows land on the same edge as the real write
   always @(posedge mclk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         {pc, dir, out, p6d} <= 32'h0;
         {en, sel} <= 16'h00ff;
      end
      else if (psel_i && penable_i && pwrite_i)
      begin
         if (paddr_i == `PPFS_OFF_INTEN) en <= pwdata_i[7:0];
         if (paddr_i == `PPFS_OFF_INTSEL) sel <= pwdata_i[7:0];
         if (paddr_i == `PPFS_OFF_PERIPH) pc <= pwdata_i[7:0];
         if (paddr_i == `PPFS_OFF_P5DIR) dir <= pwdata_i[7:0];
         if (paddr_i == `PPFS_OFF_P5OUT) out <= pwdata_i[7:0];
         if (paddr_i == `PPFS_OFF_P6DIR) p6d <= pwdata_i[7:0];
      end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_pwm_b; pc[7] |-> p5_pin_oe_o[7] && p5_pin_o[7] == pwm_ch1_out_i; endproperty
   a_pwm_b: assert property (p_pwm_b) else $error("pin 7 not pwm b");
   property p_pwm_a; pc[6] |-> p5_pin_oe_o[6] && p5_pin_o[6] == pwm_ch0_out_i; endproperty
   a_pwm_a: assert property (p_pwm_a) else $error("pin 6 not pwm a");
   property p_s2_rx; pc[5] && $past(pc[5]) && $past(pc[5], 2) |-> !p5_pin_oe_o[5] && ser2_rx_in_o == $past(p5_pin_i[5], 2);
   endproperty
   a_s2_rx: assert property (p_s2_rx) else $error("pin 5 rx path wrong");
   property p_s1_rx; pc[3] |-> !p5_pin_oe_o[3] && ser1_rx_in_o == $past(p5_pin_i[3], 2); endproperty
   a_s1_rx: assert property (p_s1_rx) else $error("pin 3 rx path wrong");
   property p_s0_rx; pc[1] |-> !p5_pin_oe_o[1] && ser0_rx_in_o == $past(p5_pin_i[1], 2); endproperty
   a_s0_rx: assert property (p_s0_rx) else $error("pin 1 rx path wrong");
   property p_ext_int; ext_int_hi_o == ($past(p5_pin_i, 2) | ~(en | ~sel)); endproperty
   a_ext_int: assert property (p_ext_int) else $error("interrupt line wrong");
   property p_s2_tx; pc[4] |-> p5_pin_oe_o[4] && p5_pin_o[4] == ser2_tx_out_i; endproperty
   a_s2_tx: assert property (p_s2_tx) else $error("pin 4 not tx");
   property p_s1_tx; pc[2] |-> p5_pin_oe_o[2] && p5_pin_o[2] == ser1_tx_out_i; endproperty
   a_s1_tx: assert property (p_s1_tx) else $error("pin 2 not tx");
   property p_s0_tx; pc[0] |-> p5_pin_oe_o[0] && p5_pin_o[0] == ser0_tx_out_i; endproperty
   a_s0_tx: assert property (p_s0_tx) else $error("pin 0 not tx");
   property p_gpio; ((p5_pin_oe_o ^ dir) & ~pc) == 8'h00 && ((p5_pin_o ^ out) & dir & ~pc) == 8'h00; endproperty
   a_gpio: assert property (p_gpio) else $error("general pin wrong");
   property p_bus; p6_is_bus_o |-> p6_pin_oe_o == 8'h00; endproperty
   a_bus: assert property (p_bus) else $error("port 6 driven as bus");
   property p_p6; !p6_is_bus_o |-> p6_pin_oe_o == p6d; endproperty
   a_p6: assert property (p_p6) else $error("port 6 direction wrong");
   c_rx: cover property (pc[5] && !ser2_rx_in_o);
   c_int: cover property (ext_int_hi_o != 8'hff);
   c_bus: cover property (p6_is_bus_o);
   c_irq: cover property (irq_o);
endmodule
bind ppfs_top ppfs_top_asserts ppfs_top_asserts_inst (.*);
`default_nettype wire

// *** verif/ppfs_board.sv ***
// Purpose: board wiring on the port 5 pins
// Assumes: board drives every pin the device leaves free
// Notes: no pull resistors, so free pins follow ext
`timescale 1ns/1ps
`default_nettype none
module ppfs_board
(
   // Device side of each pin
   input wire logic [7:0] drive_i,
   input wire logic [7:0] drive_oe_i,
   // Level the board puts on a free pin
   input wire logic [7:0] ext_i,
   // Resolved pin level
   output logic [7:0] level_o
);
   // Device wins where it drives, board elsewhere; no pulls fitted
   assign level_o = (drive_oe_i & drive_i) | (~drive_oe_i & ext_i);
endmodule
`default_nettype wire

// *** verif/tb_ppfs_top.sv ***
// Purpose: self-checking bench for the pin function select
// Assumes: zero wait APB, board model on port 5
// Notes: fixed seed keeps runs repeatable
`timescale 1ns/1ps
`default_nettype none
`include "ppfs_consts.vh"
module tb_ppfs_top;
   logic mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, r;
   logic [7:0] ext = 8'hff, p6_pin_i = 0, pc, d, o, eo, w;
   logic [4:0] tx = 0; // Peripheral outputs
   logic [2:0] rxe; // Expected receive outputs
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, ser2_rx_in_o, ser1_rx_in_o, ser0_rx_in_o, p6_is_bus_o, irq_o;
   wire [7:0] p5_pin_i, p5_pin_o, p5_pin_oe_o, ext_int_hi_o, p6_pin_oe_o;
   integer errors = 0, checks = 0, seed = 32'h6c74ea9b, i, cyc = 0;
   ppfs_top ppfs_top_inst (.pwm_ch1_out_i(tx[4]), .pwm_ch0_out_i(tx[3]), .ser2_tx_out_i(tx[2]),
      .ser1_tx_out_i(tx[1]), .ser0_tx_out_i(tx[0]), .*);
   ppfs_board ppfs_board_inst (.drive_i(p5_pin_o), .drive_oe_i(p5_pin_oe_o), .ext_i(ext), .level_o(p5_pin_i));
   always #2.5 mclk_i = ~mclk_i;
   // Hang guard
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         print_verdict;
      end
   end
   task print_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // APB cycle; slave error folded into bit 31 of r
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
      @(posedge mclk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, a, dat};
      @(posedge mclk_i);
      penable_i <= 1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      r = {pslverr_o, prdata_o[30:0]};
      {psel_i, penable_i} <= 2'b00;
   endtask
   // Expected drive enables
   function logic [7:0] f_oe(input logic [7:0] c, dd);
      f_oe = (dd & ~c) | (c & 8'hd5);
   endfunction
   initial
   begin
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1;
      repeat (2) @(posedge mclk_i);
      apb(0, `PPFS_OFF_INTSEL, 0);
      chk("intsel", r, 32'hff);
      apb(1, `PPFS_OFF_P6DIR, 32'hff);
      apb(0, `PPFS_OFF_P6DIR, 0);
      chk("p6dir", r, 0);
      apb(0, 12'h040, 0);
      chk("unmapped", r, 32'h80000000);
      $display("test reset done");
      for (i = 0; i < 40; i++)
      begin
         {pc, d, o} = $random(seed);
         if (i == 0) pc = 8'hff; // Every peripheral on
         ext <= $random(seed);
         tx <= $random(seed);
         apb(1, `PPFS_OFF_PERIPH, pc);
         apb(1, `PPFS_OFF_P5DIR, d);
         apb(1, `PPFS_OFF_P5OUT, o);
         repeat (3) @(posedge mclk_i);
         #1 eo = f_oe(pc, d);
         w = (eo & ((o & d & ~pc) | (pc & 8'hd5 & {tx[4:3], 1'b0, tx[2], 1'b0, tx[1], 1'b0, tx[0]}))) | (~eo & ext);
         rxe = {w[5] | ~pc[5], w[3] | ~pc[3], w[1] | ~pc[1]};
         chk("oe", p5_pin_oe_o, eo);
         chk("level", p5_pin_i, w);
         chk("rx", {ser2_rx_in_o, ser1_rx_in_o, ser0_rx_in_o}, rxe);
         apb(0, `PPFS_OFF_P5IN, 0);
         chk("read", r, (d & o) | (~d & w));
      end
      $display("test routing done");
      apb(1, `PPFS_OFF_PERIPH, 0);
      apb(1, `PPFS_OFF_P5DIR, 0);
      ext <= 8'h00;
      repeat (4) @(posedge mclk_i);
      #1 chk("unrouted", ext_int_hi_o, 8'hff);
      apb(1, `PPFS_OFF_INTEN, 8'h0f);
      #1 chk("enabled", ext_int_hi_o, 8'hf0);
      apb(1, `PPFS_OFF_INTSEL, 0);
      ext <= 8'hff;
      repeat (4) @(posedge mclk_i);
      ext <= 8'h00;
      repeat (4) @(posedge mclk_i);
      #1 chk("routed", ext_int_hi_o, 8'h00);
      apb(0, `PPFS_OFF_ISTAT, 0);
      chk("status", r, 32'hff);
      chk("masked", irq_o, 0);
      apb(1, `PPFS_OFF_IMASK, 1);
      #1 chk("irq", irq_o, 1);
      apb(1, `PPFS_OFF_ISTAT, 32'hff);
      #1 chk("cleared", irq_o, 0);
      $display("test interrupt done");
      apb(1, `PPFS_OFF_P6DIR, 32'h5a);
      apb(1, `PPFS_OFF_MODE, 1);
      #1 chk("p6 narrow", {p6_is_bus_o, p6_pin_oe_o}, 9'h05a);
      apb(1, `PPFS_OFF_MODE, 2);
      #1 chk("p6 wide only", {p6_is_bus_o, p6_pin_oe_o}, 9'h05a);
      apb(1, `PPFS_OFF_MODE, 3);
      #1 chk("p6 wide", {p6_is_bus_o, p6_pin_oe_o}, 9'h100);
      apb(1, `PPFS_OFF_MODE, 0);
      #1 chk("p6 single", {p6_is_bus_o, p6_pin_oe_o}, 9'h05a);
      $display("test port 6 done");
      print_verdict;
   end
endmodule
`default_nettype wire
